/* File: src/rsc_pkg.sv */
package rsc_pkg;

  // ****************************************
  // Register map.
  // ****************************************
  localparam logic [3:0] ADDR_CAUSE_STATUS = 4'h0;
  localparam logic [3:0] ADDR_SYS_CFG3     = 4'h1;
  localparam logic [3:0] ADDR_PROT_KEY     = 4'h2;
  localparam logic [3:0] ADDR_SEQ_STATUS   = 4'h3;

  // ****************************************
  // Field positions of the cause status and system config 3 registers.
  // ****************************************
  localparam int CAUSE_VOLT_POS  = 0;
  localparam int CAUSE_WDT_POS   = 1;
  localparam int CAUSE_CLK_POS   = 2;
  localparam int CAUSE_TRIM_POS  = 3;
  localparam int CAUSE_FLASH_POS = 4;
  localparam int TRIM_ERR_POS    = 5;
  localparam int CLEAR_REQ_POS   = 6;
  localparam int RESET_PIN_DISABLE_POS      = 0;

  // ****************************************
  // Keys, reset values and timing.
  // ****************************************
  localparam logic [7:0] KEY_CAUSE_CLEAR = 8'h71;
  localparam logic [7:0] KEY_PIN_CONFIG  = 8'hB2;
  localparam logic [7:0] CAUSE_RESET_VAL = 8'h00;
  localparam logic       RESET_PIN_DISABLE_RESET    = 1'b0;
  localparam int         CLK_FREQ_MHZ    = 40;
  localparam int         PIN_LOW_MIN_US  = 5;
  localparam int         PIN_LOW_CYCLES  = PIN_LOW_MIN_US * CLK_FREQ_MHZ;
  localparam int         WARMUP_CYCLES   = 1024;
  localparam int         TRIM_WORDS      = 4;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

  typedef enum logic [1:0] {RSC_IN_RESET, RSC_WARMUP, RSC_RUN} rsc_state_e;

endpackage : rsc_pkg

/* File: src/rsc_sync.sv */
// ****************************************
// Two-flop synchroniser for pins.
// ****************************************
module rsc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage; both stages reset to all ones and reset_val is not used.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

  initial begin
    if (W < 1) $error("rsc_sync width must be positive.");
  end

endmodule : rsc_sync

/* File: src/rsc_trim_mem.sv */
// ****************************************
// Trim latch memory with registered read.
// ****************************************
module rsc_trim_mem #(
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);

  logic [7:0] mem_q [DEPTH];

  // Stores latched trim words.
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read data comes out of a register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

  initial begin
    if (DEPTH > (1 << AW)) $error("rsc_trim_mem depth exceeds address range.");
  end

endmodule : rsc_trim_mem

/* File: src/rsc_reset_ctrl.sv */
// Overview of operation
// - Internal reset is POR OR pin OR factor.
// - Warm-up starts when last source releases.
// - Shared pin powers up as reset input.
// - Pin low five microseconds resets device.
// - Pin rising edge starts warm-up, then run.
// - Detector holds and reasserts reset.
// - Voltage detection raises factor reset.
// - Watchdog overflow raises factor reset.
// - Deadlock clock setting raises factor reset.
// - Corrupted trim latch raises factor reset.
// - Warm-up loads trim, flags abnormal data.
// - Flash access in standby resets device.
// - Cause flag records internal factor.
// - Pin or POR reset clears causes.
// - Clear request plus key 71 clears.
// - Disable bit plus key B2 frees pin.
// - Cleared bit plus key B2 restores reset.
// - Reset during warm-up restarts the count.
// - CPU starts at topmost vector address.
// - Cause status bit seven reads zero.
module rsc_reset_ctrl #(
  parameter int WARMUP_CYCLES = rsc_pkg::WARMUP_CYCLES,
  parameter int TRIM_WORDS    = rsc_pkg::TRIM_WORDS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        por_active,
  input  wire logic        reset_pin_in,
  input  wire logic        volt_detect_evt,
  input  wire logic        wdt_overflow_evt,
  input  wire logic        clk_deadlock_evt,
  input  wire logic        trim_corrupt_evt,
  input  wire logic        flash_standby_access_evt,
  input  wire logic [7:0]  trim_nvm_data,
  input  wire logic        trim_nvm_valid,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             sys_reset_n,
  output logic             cpu_run,
  output logic      [15:0] reset_vector_addr,
  output logic             pin_is_port,
  output logic             trim_load_req,
  output logic      [7:0]  trim_latch_data
);

  // ****************************************
  // Elaboration checks.
  // ****************************************
  localparam int WCW = $clog2(WARMUP_CYCLES + 1);
  localparam int TAW = (TRIM_WORDS > 1) ? $clog2(TRIM_WORDS) : 1;
  localparam int PCW = $clog2(rsc_pkg::PIN_LOW_CYCLES + 1);

  initial begin
    if (WARMUP_CYCLES < 1) $error("Warm-up length must be at least one cycle.");
    if (TRIM_WORDS < 1) $error("At least one trim word is needed.");
    if (TRIM_WORDS > WARMUP_CYCLES) $error("Trim load must fit inside warm-up.");
  end

  // ****************************************
  // Pin and detector synchronisers.
  // ****************************************
  logic [1:0] sync_raw;
  logic [1:0] sync_val;
  logic       pin_s;
  logic       por_s;

  assign sync_raw = {reset_pin_in, por_active};
  assign pin_s    = sync_val[1];
  assign por_s    = sync_val[0];

  rsc_sync #(
    .W (2)
  ) u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .async_in  (sync_raw),
    .reset_val (2'b11),
    .sync_out  (sync_val)
  );

  // ****************************************
  // Register state.
  // ****************************************
  rsc_pkg::rsc_state_e state_q;
  rsc_pkg::rsc_state_e state_d;
  logic [4:0]     cause_q;
  logic           trim_err_q;
  logic           clear_req_q;
  logic           reset_pin_disable_q;
  logic           reset_pin_disable_active_q;
  logic [PCW-1:0] pin_low_cnt_q;
  logic [WCW-1:0] warm_cnt_q;
  logic [TAW:0]   trim_idx_q;
  logic           ext_rst_q;

  // ****************************************
  // Decode and reset combining.
  // ****************************************
  logic       wr_cause;
  logic       wr_cfg3;
  logic       wr_key;
  logic       key_clear;
  logic       key_pin;
  logic       pin_low_long;
  logic       ext_reset;
  logic [4:0] factor_evt;
  logic       factor_reset;
  logic       any_reset;
  logic       trim_wr;
  logic       trim_bad;

  assign wr_cause  = reg_wr && (reg_addr == rsc_pkg::ADDR_CAUSE_STATUS);
  assign wr_cfg3   = reg_wr && (reg_addr == rsc_pkg::ADDR_SYS_CFG3);
  assign wr_key    = reg_wr && (reg_addr == rsc_pkg::ADDR_PROT_KEY);
  assign key_clear = wr_key && (reg_wdata == rsc_pkg::KEY_CAUSE_CLEAR) && clear_req_q;
  assign key_pin   = wr_key && (reg_wdata == rsc_pkg::KEY_PIN_CONFIG);

  // Pin must stay low long enough before it counts as a reset in run.
  assign pin_low_long = (pin_low_cnt_q == PCW'(rsc_pkg::PIN_LOW_CYCLES));
  // During power-on reset and warm-up the pin acts at once; in run it needs 5 us.
  assign ext_reset = !reset_pin_disable_active_q &&
                     ((state_q != rsc_pkg::RSC_RUN) ? !pin_s : pin_low_long);

  assign factor_evt = {flash_standby_access_evt,
                       trim_corrupt_evt,
                       clk_deadlock_evt,
                       wdt_overflow_evt,
                       volt_detect_evt};
  assign factor_reset = (state_q == rsc_pkg::RSC_RUN) && (|factor_evt);
  assign any_reset    = por_s || ext_reset || factor_reset;

  assign trim_wr  = (state_q == rsc_pkg::RSC_WARMUP) && trim_nvm_valid &&
                    (trim_idx_q < (TAW + 1)'(TRIM_WORDS));
  assign trim_bad = trim_wr && ((trim_nvm_data == 8'h00) || (trim_nvm_data == 8'hFF));

  // ****************************************
  // Sequencer.
  // ****************************************
  // Reset holds while any source is active; warm-up follows the last release.
  always_comb begin
    state_d = state_q;
    case (state_q)
      rsc_pkg::RSC_IN_RESET: begin
        if (!any_reset) begin
          state_d = rsc_pkg::RSC_WARMUP;
        end
      end
      rsc_pkg::RSC_WARMUP: begin
        if (any_reset) begin
          state_d = rsc_pkg::RSC_IN_RESET;
        end else if (warm_cnt_q == WCW'(WARMUP_CYCLES - 1)) begin
          state_d = rsc_pkg::RSC_RUN;
        end
      end
      rsc_pkg::RSC_RUN: begin
        if (any_reset) begin
          state_d = rsc_pkg::RSC_IN_RESET;
        end
      end
      default: state_d = rsc_pkg::RSC_IN_RESET;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rsc_pkg::RSC_IN_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Warm-up counter is cleared whenever reset is present.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_cnt_q <= '0;
    end else if (state_q != rsc_pkg::RSC_WARMUP || any_reset) begin
      warm_cnt_q <= '0;
    end else begin
      warm_cnt_q <= warm_cnt_q + WCW'(1);
    end
  end

  // Counts low time of the pin, saturating at the qualifying figure.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_low_cnt_q <= '0;
    end else if (pin_s) begin
      pin_low_cnt_q <= '0;
    end else if (!pin_low_long) begin
      pin_low_cnt_q <= pin_low_cnt_q + PCW'(1);
    end
  end

  // Remembers whether the last reset came from pin or detector.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_rst_q <= 1'b1;
    end else if (por_s || ext_reset) begin
      ext_rst_q <= 1'b1;
    end else if (factor_reset) begin
      ext_rst_q <= 1'b0;
    end
  end

  // ****************************************
  // Trim loading.
  // ****************************************
  // Index walks the trim words once per warm-up.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_idx_q <= '0;
    end else if (state_q != rsc_pkg::RSC_WARMUP) begin
      trim_idx_q <= '0;
    end else if (trim_wr) begin
      trim_idx_q <= trim_idx_q + (TAW + 1)'(1);
    end
  end

  rsc_trim_mem #(
    .DEPTH (TRIM_WORDS),
    .AW    (TAW)
  ) u_trim (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (trim_wr),
    .wr_addr  (trim_idx_q[TAW-1:0]),
    .wr_data  (trim_nvm_data),
    .rd_addr  (reg_wdata[TAW-1:0]),
    .rd_data  (trim_latch_data)
  );

  // ****************************************
  // Cause status and key sequences.
  // ****************************************
  // Cause flags: events win over clears; pin and detector resets wipe them.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q     <= rsc_pkg::CAUSE_RESET_VAL[4:0];
      clear_req_q <= 1'b0;
    end else begin
      if (por_s || ext_reset) begin
        cause_q <= rsc_pkg::CAUSE_RESET_VAL[4:0];
      end else if (factor_reset) begin
        cause_q <= cause_q | factor_evt;
      end else if (key_clear) begin
        cause_q <= rsc_pkg::CAUSE_RESET_VAL[4:0];
      end
      if (key_clear || por_s || ext_reset) begin
        clear_req_q <= 1'b0;
      end else if (wr_cause) begin
        clear_req_q <= reg_wdata[rsc_pkg::CLEAR_REQ_POS];
      end
    end
  end

  // Trim error flag is set during warm-up loading and cleared while in reset or by the clear key.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_err_q <= 1'b0;
    end else if (trim_bad) begin
      trim_err_q <= 1'b1;
    end else if (state_q == rsc_pkg::RSC_IN_RESET) begin
      trim_err_q <= 1'b0;
    end else if (key_clear) begin
      trim_err_q <= 1'b0;
    end
  end

  // Pin disable bit takes effect only after the key write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_disable_q        <= rsc_pkg::RESET_PIN_DISABLE_RESET;
      reset_pin_disable_active_q <= rsc_pkg::RESET_PIN_DISABLE_RESET;
    end else begin
      if (wr_cfg3) begin
        reset_pin_disable_q <= reg_wdata[rsc_pkg::RESET_PIN_DISABLE_POS];
      end
      if (key_pin) begin
        reset_pin_disable_active_q <= reset_pin_disable_q;
      end
    end
  end

  // ****************************************
  // Read data and outputs.
  // ****************************************
  logic [7:0] rd_mux;

  assign rd_mux = (reg_addr == rsc_pkg::ADDR_CAUSE_STATUS) ?
                    {1'b0, clear_req_q, trim_err_q, cause_q} :
                  (reg_addr == rsc_pkg::ADDR_SYS_CFG3) ? {7'h00, reset_pin_disable_q} :
                  (reg_addr == rsc_pkg::ADDR_SEQ_STATUS) ?
                    {4'h0, ext_rst_q, reset_pin_disable_active_q, 2'(state_q)} : 8'h00;

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Registered system outputs.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_n       <= 1'b0;
      cpu_run           <= 1'b0;
      pin_is_port       <= 1'b0;
      trim_load_req     <= 1'b0;
      reset_vector_addr <= rsc_pkg::RESET_VECTOR_ADDR;
    end else begin
      sys_reset_n       <= (state_d != rsc_pkg::RSC_IN_RESET);
      cpu_run           <= (state_d == rsc_pkg::RSC_RUN);
      pin_is_port       <= reset_pin_disable_active_q;
      trim_load_req     <= (state_d == rsc_pkg::RSC_WARMUP) &&
                           (trim_idx_q < (TAW + 1)'(TRIM_WORDS));
      reset_vector_addr <= rsc_pkg::RESET_VECTOR_ADDR;
    end
  end

endmodule : rsc_reset_ctrl

/* File: bench/rsc_board.sv */
// ******
// Board supervisor driving the supply flag and the reset pin.
// ******
module rsc_board (
  input  wire logic core_clk,
  input  wire logic supply_ok,
  input  wire logic slow_rise,
  input  wire logic pin_pull_low,
  output logic      por_active   = 1'b1,
  output logic      reset_pin_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold_q = 8'hD2;
  // A slow supply keeps the pin low until 210 cycles after it settles.
  wire  [7:0] hold_d = (!supply_ok && slow_rise) ? 8'hD2 :
                       (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
  // The pull-up holds the pin high unless the button or the hold pulls it.
  always_ff @(posedge core_clk) begin
    hold_q       <= hold_d;
    por_active   <= !supply_ok;
    reset_pin_in <= !(pin_pull_low || hold_d != 8'h00);
  end
endmodule // rsc_board

/* File: bench/rsc_reset_ctrl_chk.sv */
// ******
// Port checker for the reset controller.
// ******
module rsc_reset_ctrl_chk #(
  parameter int W = 16
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        por_active,
  input wire logic        reset_pin_in,
  input wire logic        volt_detect_evt,
  input wire logic        wdt_overflow_evt,
  input wire logic        clk_deadlock_evt,
  input wire logic        trim_corrupt_evt,
  input wire logic        flash_standby_access_evt,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        sys_reset_n,
  input wire logic        cpu_run,
  input wire logic [15:0] reset_vector_addr,
  input wire logic        pin_is_port,
  input wire logic        trim_load_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] wcnt_q;
  logic [8:0]  low_q;
  // Warm-up cycles so far and cycles of a low pin while it is a reset input.
  wire  [15:0] wcnt_d = (sys_reset_n && !cpu_run) ? wcnt_q + 16'h0001 : 16'h0000;
  wire         pin_low = !reset_pin_in && !pin_is_port;
  wire  [8:0]  low_d = pin_low ? low_q + {8'h00, low_q != 9'h1FF} : 9'h000;
  wire         any_evt = volt_detect_evt | wdt_overflow_evt | clk_deadlock_evt |
                         trim_corrupt_evt | flash_standby_access_evt;
  wire         key_b2 = reg_wr && reg_addr == 4'h2 && reg_wdata == 8'hB2;
  // Counter registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_q <= 16'h0000;
      low_q  <= 9'h000;
    end else begin
      wcnt_q <= wcnt_d;
      low_q  <= low_d;
    end
  end
  sequence fac_s;
    cpu_run && sys_reset_n && any_evt;
  endsequence
  vec_fixed_a: assert property (reset_vector_addr == 16'hFFFE)
    else $error("reset vector moved");
  run_gate_a: assert property (!sys_reset_n [*2] |-> !cpu_run)
    else $error("cpu runs in reset");
  por_hold_a: assert property (por_active [*6] |-> !sys_reset_n)
    else $error("detector did not hold reset");
  pin_hold_a: assert property (low_q >= 9'h0D2 |-> !sys_reset_n)
    else $error("long low pin did not reset");
  factor_rst_a: assert property (fac_s |-> ##[1:4] !sys_reset_n)
    else $error("factor event did not reset");
  warm_len_a: assert property ($rose(cpu_run) |-> wcnt_q >= 16'(W - 1))
    else $error("warm-up too short");
  warm_max_a: assert property (wcnt_q <= 16'(W + 3))
    else $error("warm-up too long");
  release_a: assert property ($rose(sys_reset_n) |-> !$past(por_active, 2))
    else $error("release while detector active");
  port_key_a: assert property ($rose(pin_is_port) |-> $past(key_b2) || $past(key_b2, 2))
    else $error("pin freed without key");
  bit_seven_a: assert property (reg_rd && reg_addr == 4'h0 |=> !reg_rdata[7])
    else $error("status bit seven set");
  trim_req_a: assert property (trim_load_req |-> !cpu_run)
    else $error("trim load outside warm-up");
endmodule // rsc_reset_ctrl_chk

/* File: bench/rsc_reset_ctrl_tb.sv */
module rsc_reset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 16;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        supply_ok = 1'b0;
  logic        slow_rise = 1'b1;
  logic        pin_pull_low = 1'b0;
  logic        bad_trim = 1'b0;
  logic [4:0]  evt = 5'h00;
  logic [7:0]  trim_nvm_data = 8'h5A;
  logic        trim_nvm_valid = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire         por_active;
  wire         reset_pin_in;
  wire  [7:0]  reg_rdata;
  wire         sys_reset_n;
  wire         cpu_run;
  wire  [15:0] vec;
  wire         pin_is_port;
  wire         trim_load_req;
  wire  [7:0]  trim_latch;
  int          failures = 0;
  int          n_checks = 0;
  int          warm;
  rsc_board board_u (.core_clk, .supply_ok, .slow_rise, .pin_pull_low, .por_active,
                     .reset_pin_in);
  rsc_reset_ctrl #(.WARMUP_CYCLES(W)) dut_u (
    .core_clk, .rst_n, .por_active, .reset_pin_in, .volt_detect_evt(evt[0]),
    .wdt_overflow_evt(evt[1]), .clk_deadlock_evt(evt[2]), .trim_corrupt_evt(evt[3]),
    .flash_standby_access_evt(evt[4]), .trim_nvm_data, .trim_nvm_valid, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_reset_n, .cpu_run,
    .reset_vector_addr(vec), .pin_is_port, .trim_load_req, .trim_latch_data(trim_latch)
  );
  // Clock of 25 ns.
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Trim store answers each request with a fresh word.
  always @(posedge core_clk) begin
    trim_nvm_valid <= trim_load_req;
    trim_nvm_data  <= bad_trim ? 8'h00 : 8'h01 + 8'($urandom % 254);
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic keep);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    if (!keep) begin
      reg_wr <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(what, {8'h00, reg_rdata}, {8'h00, e});
    @(posedge core_clk);
  endtask
  // Waits for reset entry, then measures the warm-up up to cpu_run.
  task automatic wait_run(input int lim);
    int k;
    warm = 0;
    for (k = 0; cpu_run === 1'b1; k++) begin
      @(negedge core_clk);
      if (k == lim) check("timeout", 16'h0001, 16'h0000);
      if (k == lim) print_verdict();
    end
    for (k = 0; cpu_run !== 1'b1; k++) begin
      @(negedge core_clk);
      warm = (sys_reset_n === 1'b1) ? warm + 1 : 0;
      if (k == 3000) check("timeout", 16'h0001, 16'h0000);
      if (k == 3000) print_verdict();
    end
    @(posedge core_clk);
    check("warm-up", 16'(warm >= W), 16'h0001);
  endtask
  task automatic fire(input int i);
    evt <= 5'h01 << i;
    @(posedge core_clk);
    evt <= 5'h00;
  endtask
  // Main sequence.
  initial begin
    logic [7:0] exp;
    int         i;
    void'($urandom(78));
    exp = 8'h00;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    check("held low", 16'(sys_reset_n), 16'h0000);
    supply_ok <= 1'b1;
    wait_run(5);
    check("vector", vec, 16'hFFFE);
    check("pin at power", 16'(pin_is_port), 16'h0000);
    rchk("cause at power", 4'h0, 8'h00);
    for (i = 0; i < 5; i++) begin
      bad_trim <= (i == 2);
      fire(i);
      wait_run(20);
      exp[i] = 1'b1;
      rchk("cause", 4'h0, exp | (i == 2 ? 8'h20 : 8'h00));
      check("trim latch", 16'(trim_latch == 8'h00), 16'(i == 2));
      rchk("seq factor", 4'h3, 8'h02);
    end
    wr(4'h2, 8'h71, 1'b0);
    rchk("key alone", 4'h0, exp);
    wr(4'h0, 8'h40, 1'b1);
    wr(4'h2, 8'h71, 1'b0);
    rchk("cleared", 4'h0, 8'h00);
    fire($urandom % 5);
    fork
      wait_run(20);
      begin
        repeat (8) @(posedge core_clk);
        pin_pull_low <= 1'b1;
        repeat (3) @(posedge core_clk);
        pin_pull_low <= 1'b0;
      end
    join
    rchk("cause after pin", 4'h0, 8'h00);
    pin_pull_low <= 1'b1;
    repeat (215) @(posedge core_clk);
    check("pin reset", 16'(sys_reset_n), 16'h0000);
    pin_pull_low <= 1'b0;
    wait_run(5);
    wr(4'h1, 8'h01, 1'b1);
    wr(4'h2, 8'hB2, 1'b0);
    repeat (3) @(posedge core_clk);
    check("port on", 16'(pin_is_port), 16'h0001);
    rchk("cfg3", 4'h1, 8'h01);
    rchk("seq pin", 4'h3, 8'h0E);
    pin_pull_low <= 1'b1;
    repeat (300) @(posedge core_clk);
    check("port low", 16'(sys_reset_n), 16'h0001);
    pin_pull_low <= 1'b0;
    repeat (5) @(posedge core_clk);
    wr(4'h1, 8'h00, 1'b1);
    wr(4'h2, 8'hB2, 1'b0);
    repeat (3) @(posedge core_clk);
    check("port off", 16'(pin_is_port), 16'h0000);
    slow_rise <= 1'b0;
    supply_ok <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("supply drop", 16'(sys_reset_n), 16'h0000);
    supply_ok <= 1'b1;
    wait_run(5);
    for (i = 0; i < 4; i++) begin
      rchk("unmapped", 4'h4 + 4'($urandom % 12), 8'h00);
    end
    print_verdict();
  end
endmodule // rsc_reset_ctrl_tb
bind rsc_reset_ctrl rsc_reset_ctrl_chk #(.W(WARMUP_CYCLES)) chk_u (
  .core_clk, .rst_n, .por_active, .reset_pin_in, .volt_detect_evt, .wdt_overflow_evt,
  .clk_deadlock_evt, .trim_corrupt_evt, .flash_standby_access_evt, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .sys_reset_n, .cpu_run, .reset_vector_addr, .pin_is_port,
  .trim_load_req
);
